// ==== rtl/timer_mode_pkg.sv ====
// Package: mode encodings, reset values and timing figures for the timer mode control
package timer_mode_pkg;

	// ------------------------------------------------------------
	// Mode field layout
	// ------------------------------------------------------------
	localparam int MODE_W      = 5;
	localparam int CLASS_MSB   = 4;
	localparam int CLASS_LSB   = 3;
	localparam int OPTION_MSB  = 2;
	localparam int OPTION_LSB  = 0;
	localparam int COUNT_W     = 8;

	// ------------------------------------------------------------
	// Class codes (upper two mode bits)
	// ------------------------------------------------------------
	localparam logic [1:0] CLASS_FREE_RUN   = 2'h0;
	localparam logic [1:0] CLASS_ONE_SHOT   = 2'h1;
	localparam logic [1:0] CLASS_MONOSTABLE = 2'h2;

	// ------------------------------------------------------------
	// Option codes (lower three mode bits)
	// ------------------------------------------------------------
	localparam logic [2:0] OPT_SOFT        = 3'h0;
	localparam logic [2:0] OPT_GATE_HIGH   = 3'h1;
	localparam logic [2:0] OPT_GATE_LOW    = 3'h2;
	localparam logic [2:0] OPT_ANY_EDGE    = 3'h3;
	localparam logic [2:0] OPT_RISE_EDGE   = 3'h4;
	localparam logic [2:0] OPT_FALL_EDGE   = 3'h5;
	localparam logic [2:0] OPT_LOW_LEVEL   = 3'h6;
	localparam logic [2:0] OPT_HIGH_LEVEL  = 3'h7;

	// ------------------------------------------------------------
	// Values after reset
	// ------------------------------------------------------------
	localparam logic [COUNT_W-1:0] COUNT_RESET  = 8'h00;
	localparam logic [COUNT_W-1:0] PERIOD_RESET = 8'hff;

	// ------------------------------------------------------------
	// Least spacing the trigger source must keep, in timer clocks
	// ------------------------------------------------------------
	localparam int EDGE_SPACING_CYCLES = 6;
	localparam int LEVEL_HOLD_CYCLES   = 3;

	// Sequencing of the start-controlled classes
	typedef enum logic [1:0] {
		ST_IDLE,
		ST_ARMED,
		ST_COUNTING
	} run_state_t;

endpackage : timer_mode_pkg

// ==== rtl/ers_sync.sv ====
// External reset signal synchroniser with debug freeze and edge detection
`timescale 1ns/10ps
module ers_sync (
	input  wire logic i_clk,
	input  wire logic i_rst,
	input  wire logic i_ext,
	input  wire logic i_freeze,
	output logic      o_level,
	output logic      o_rise,
	output logic      o_fall
);
	import timer_mode_pkg::*;

	logic meta_q, meta_d;
	logic sync_q, sync_d;
	logic level_q, level_d;

	// ------------------------------------------------------------
	// Next values
	// ------------------------------------------------------------
	// Frozen level hides every edge while debug holds the block
	always_comb begin
		meta_d  = i_ext;
		sync_d  = meta_q;
		level_d = i_freeze ? level_q : sync_q;
	end

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			meta_q  <= 1'b0;
			sync_q  <= 1'b0;
			level_q <= 1'b0;
		end else begin
			meta_q  <= meta_d;
			sync_q  <= sync_d;
			level_q <= level_d;
		end
	end

	// Edges compare the second stage against the held level
	assign o_level = level_q;
	assign o_rise  = !i_freeze && sync_q && !level_q;
	assign o_fall  = !i_freeze && !sync_q && level_q;

endmodule : ers_sync

// ==== rtl/count_core.sv ====
// Eight-bit count register with load, clear and advance
`timescale 1ns/10ps
module count_core #(
	parameter int WIDTH = 8
) (
	input  wire logic             i_clk,
	input  wire logic             i_rst,
	input  wire logic             i_load,
	input  wire logic [WIDTH-1:0] i_load_value,
	input  wire logic             i_clear,
	input  wire logic             i_advance,
	input  wire logic [WIDTH-1:0] i_period,
	output logic      [WIDTH-1:0] o_count,
	output logic                  o_at_period
);
	import timer_mode_pkg::*;

	logic [WIDTH-1:0] count_q, count_d;

	// ------------------------------------------------------------
	// Next count
	// ------------------------------------------------------------
	// Software load beats hardware clear, clear beats advance
	always_comb begin
		count_d = count_q;
		if (i_load) begin
			count_d = i_load_value;
		end else if (i_clear) begin
			count_d = WIDTH'(COUNT_RESET);
		end else if (i_advance) begin
			count_d = count_q + WIDTH'(1);
		end
	end

	// ------------------------------------------------------------
	// Register
	// ------------------------------------------------------------
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			count_q <= WIDTH'(COUNT_RESET);
		end else begin
			count_q <= count_d;
		end
	end

	assign o_count     = count_q;
	assign o_at_period = (count_q == i_period);

endmodule : count_core

// ==== rtl/timer_mode_control.sv ====
// Mode selection and start, reset and stop control of an eight-bit period timer
//
// Summary of operation
// R1 - Five-bit mode: upper two bits pick class, lower three pick start/reset option.
// R2 - Trigger source keeps edges at least six timer clocks apart.
// R3 - Trigger source holds each triggering level at least three timer clocks.
// R4 - In debug mode all external reset signal activity is ignored.
// R5 - Code 00000 counts only while run enable is set; no external reset.
// R6 - Codes 00001 and 00010 add external gating, high and low active.
// R7 - Code 00011 runs on enable and resets on either external edge.
// R8 - Code 00100 resets on rising edge, 00101 on falling edge.
// R9 - Code 00110 holds reset while low, 00111 while high.
// R10 - Code 01000 starts one period when software sets run enable.
// R11 - Codes 01001 to 01011 start one-shot on rising, falling or any edge.
// R12 - Codes 01100 and 01101 start and reset on rising or falling edges.
// R13 - 01110 rising start, low reset; 01111 falling start, high reset.
// R14 - One-shot period match clears run enable and stops at zero next clock.
// R15 - Edge-start modes need a fresh edge after run enable was cleared.
// R16 - Monostable match stops at zero, keeps run enable, later edge restarts; 10110 and 10111 clear run enable instead.
// R17 - 10110 starts on high, resets on low; 10111 the inverse.
// R18 - Reserved mode codes are never programmed by software.
`timescale 1ns/10ps
module timer_mode_control #(
	parameter int COUNT_W = 8
) (
	input  wire logic                          i_clk,
	input  wire logic                          i_rst,
	input  wire logic [timer_mode_pkg::MODE_W-1:0] i_mode,
	input  wire logic                          i_run_set,
	input  wire logic                          i_run_clr,
	input  wire logic [COUNT_W-1:0]            i_period_value,
	input  wire logic                          i_count_write,
	input  wire logic [COUNT_W-1:0]            i_count_wdata,
	input  wire logic                          i_external_reset_signal,
	input  wire logic                          i_debug_mode,
	output logic      [COUNT_W-1:0]            o_count_value,
	output logic                               o_run_enable,
	output logic                               o_period_event,
	output logic                               o_counting
);
	import timer_mode_pkg::*;

	// ------------------------------------------------------------
	// Mode decoding helpers
	// ------------------------------------------------------------
	// Start edge of every edge-started option
	function automatic logic start_edge(input logic [2:0] opt, input logic rise, input logic fall);
		unique case (opt)
			OPT_GATE_HIGH, OPT_RISE_EDGE, OPT_LOW_LEVEL:  start_edge = rise;
			OPT_GATE_LOW, OPT_FALL_EDGE, OPT_HIGH_LEVEL:  start_edge = fall;
			OPT_ANY_EDGE:                                 start_edge = rise | fall;
			default:                                      start_edge = 1'b0;
		endcase
	endfunction : start_edge

	// Level that holds the count reset in the level options
	function automatic logic level_reset(input logic [2:0] opt, input logic level);
		level_reset = ((opt == OPT_LOW_LEVEL) && !level) || ((opt == OPT_HIGH_LEVEL) && level);
	endfunction : level_reset

	// Reserved codes leave the timer idle
	function automatic logic mode_reserved(input logic [1:0] cls, input logic [2:0] opt);
		mode_reserved = (cls == CLASS_MONOSTABLE &&
			(opt == OPT_SOFT || opt == OPT_RISE_EDGE || opt == OPT_FALL_EDGE)) ||
			(cls == 2'h3);
	endfunction : mode_reserved

	// ------------------------------------------------------------
	// Signals
	// ------------------------------------------------------------
	logic [1:0]         mode_class;
	logic [2:0]         mode_option;
	logic               ers_level;
	logic               ers_rise;
	logic               ers_fall;
	logic [COUNT_W-1:0] count_now;
	logic               at_period;
	logic               cnt_clear;
	logic               cnt_advance;
	logic               run_q, run_d;
	logic               event_q, event_d;
	logic               counting_q, counting_d;
	run_state_t         state_q, state_d;

	assign mode_class  = i_mode[CLASS_MSB:CLASS_LSB];   // see R1
	assign mode_option = i_mode[OPTION_MSB:OPTION_LSB]; // see R1

	// ------------------------------------------------------------
	// External reset signal conditioning
	// ------------------------------------------------------------
	// Pin is asynchronous; debug freezes the level so no edge appears
	ers_sync u_ers_sync (
		.i_clk    (i_clk),
		.i_rst    (i_rst),
		.i_ext    (i_external_reset_signal),
		.i_freeze (i_debug_mode),            // see R4
		.o_level  (ers_level),
		.o_rise   (ers_rise),
		.o_fall   (ers_fall)
	);

	// ------------------------------------------------------------
	// Count register
	// ------------------------------------------------------------
	count_core #(
		.WIDTH (COUNT_W)
	) u_count_core (
		.i_clk        (i_clk),
		.i_rst        (i_rst),
		.i_load       (i_count_write),
		.i_load_value (i_count_wdata),
		.i_clear      (cnt_clear),
		.i_advance    (cnt_advance),
		.i_period     (i_period_value),
		.o_count      (count_now),
		.o_at_period  (at_period)
	);

	// ------------------------------------------------------------
	// Control next state
	// ------------------------------------------------------------
	// Software set wins over a hardware clear in the same cycle,
	// so a restart request is never lost at the end of a shot.
	always_comb begin
		state_d     = state_q;
		run_d       = run_q;
		event_d     = 1'b0;
		cnt_clear   = 1'b0;
		cnt_advance = 1'b0;

		if (i_run_clr) begin
			run_d = 1'b0;
		end

		if (mode_reserved(mode_class, mode_option)) begin
			// Undefined codes: force the sequencer idle, no count advance or clear
			state_d = ST_IDLE;
		end else if (mode_class == CLASS_FREE_RUN) begin
			state_d = run_q ? ST_COUNTING : ST_IDLE;
			if (run_q) begin
				unique case (mode_option)
					OPT_SOFT: begin
						cnt_advance = 1'b1;                      // see R5
					end
					OPT_GATE_HIGH: begin
						cnt_advance = ers_level;                 // see R6
					end
					OPT_GATE_LOW: begin
						cnt_advance = !ers_level;                // see R6
					end
					OPT_ANY_EDGE: begin
						cnt_clear   = ers_rise | ers_fall;       // see R7
						cnt_advance = 1'b1;
					end
					OPT_RISE_EDGE: begin
						cnt_clear   = ers_rise;                  // see R8
						cnt_advance = 1'b1;
					end
					OPT_FALL_EDGE: begin
						cnt_clear   = ers_fall;                  // see R8
						cnt_advance = 1'b1;
					end
					OPT_LOW_LEVEL, OPT_HIGH_LEVEL: begin
						cnt_clear   = level_reset(mode_option, ers_level); // see R9
						cnt_advance = 1'b1;
					end
				endcase
				// Period match wraps to zero on the next clock
				if (cnt_advance && !cnt_clear && at_period) begin
					cnt_clear   = 1'b1;
					cnt_advance = 1'b0;
					event_d     = 1'b1;
				end
			end
		end else begin
			// One-shot and monostable share one sequencer
			unique case (state_q)
				ST_IDLE: begin
					if (run_q) begin
						state_d = ST_ARMED;
					end
				end
				ST_ARMED: begin
					if (!run_q) begin
						state_d = ST_IDLE;
					end else if (mode_class == CLASS_ONE_SHOT && mode_option == OPT_SOFT) begin
						state_d = ST_COUNTING;                   // see R10
					end else if (mode_class == CLASS_MONOSTABLE &&
						(mode_option == OPT_LOW_LEVEL || mode_option == OPT_HIGH_LEVEL)) begin
						if (!level_reset(mode_option, ers_level)) begin
							state_d = ST_COUNTING;               // see R17
						end
					end else if (start_edge(mode_option, ers_rise, ers_fall)) begin
						state_d = ST_COUNTING;                   // see R11 R13 R16
					end
				end
				ST_COUNTING: begin
					if (!run_q) begin
						// Halted: edge-start modes need a fresh edge to resume
						state_d = ST_IDLE;                       // see R15
					end else if (mode_class == CLASS_ONE_SHOT && (mode_option == OPT_RISE_EDGE ||
						mode_option == OPT_FALL_EDGE) && start_edge(mode_option, ers_rise, ers_fall)) begin
						cnt_clear = 1'b1;                        // see R12
					end else if (mode_class == CLASS_ONE_SHOT &&
						level_reset(mode_option, ers_level)) begin
						cnt_clear = 1'b1;                        // see R13
					end else if (mode_class == CLASS_MONOSTABLE &&
						level_reset(mode_option, ers_level)) begin
						cnt_clear = 1'b1;                        // see R17
						state_d   = ST_ARMED;
					end else if (at_period) begin
						cnt_clear = 1'b1;
						event_d   = 1'b1;
						if (mode_class == CLASS_ONE_SHOT ||
							mode_option == OPT_LOW_LEVEL || mode_option == OPT_HIGH_LEVEL) begin
							run_d   = 1'b0;                      // see R14
							state_d = ST_IDLE;
						end else begin
							state_d = ST_ARMED;                  // see R16
						end
					end else begin
						cnt_advance = 1'b1;
					end
				end
			endcase
		end

		if (i_run_set) begin
			run_d = 1'b1;
		end
		counting_d = (state_d == ST_COUNTING);
	end

	// ------------------------------------------------------------
	// Control registers
	// ------------------------------------------------------------
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			state_q    <= ST_IDLE;
			run_q      <= 1'b0;
			event_q    <= 1'b0;
			counting_q <= 1'b0;
		end else begin
			state_q    <= state_d;
			run_q      <= run_d;
			event_q    <= event_d;
			counting_q <= counting_d;
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	assign o_count_value  = count_now;
	assign o_run_enable   = run_q;
	assign o_period_event = event_q;
	assign o_counting     = counting_q;

endmodule : timer_mode_control

// ==== verification/ers_source.sv ====
// Partner model: source of the external reset signal
`timescale 1ns/10ps
module ers_source (
	input  wire logic i_clk,
	input  wire logic i_level,
	output logic      o_ers
);
	logic [3:0] gap_q;

	// ------------------------------------------------------------
	// Level follower
	// ------------------------------------------------------------
	// Never moves sooner than six clocks after its last move, so edges and levels stay legal
	always @(posedge i_clk) begin
		if (i_level != o_ers && gap_q >= 4'h6) begin
			o_ers <= i_level;
			gap_q <= 4'h0;
		end else if (gap_q != 4'hf) begin
			gap_q <= gap_q + 4'h1;
		end
	end

	// Start low and ready to move at once
	initial begin
		o_ers = 1'b0;
		gap_q = 4'hf;
	end
endmodule : ers_source

// ==== verification/timer_mode_control_assertions.sv ====
// Checker: timing properties of the timer mode control ports
`timescale 1ns/10ps
module timer_mode_control_checker #(
	parameter int COUNT_W = 8
) (
	input wire logic                               i_clk,
	input wire logic                               i_rst,
	input wire logic [timer_mode_pkg::MODE_W-1:0] i_mode,
	input wire logic                               i_run_set,
	input wire logic                               i_run_clr,
	input wire logic [COUNT_W-1:0]                 i_period_value,
	input wire logic                               i_count_write,
	input wire logic [COUNT_W-1:0]                 i_count_wdata,
	input wire logic                               i_external_reset_signal,
	input wire logic                               i_debug_mode,
	input wire logic [COUNT_W-1:0]                 o_count_value,
	input wire logic                               o_run_enable,
	input wire logic                               o_period_event,
	input wire logic                               o_counting
);
	import timer_mode_pkg::*;
	logic nw;
	logic at_per;
	logic dbg4;

	// Shorthands: no count load pending, count at period, debug held the three previous clocks
	assign nw = !i_count_write;
	assign at_per = o_count_value == i_period_value;
	always_ff @(posedge i_clk) begin
		dbg4 <= i_debug_mode && $past(i_debug_mode) && $past(i_debug_mode, 2);
	end

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_rst);

	// ------------------------------------------------------------
	// Properties
	// ------------------------------------------------------------
	AST_RUN_SET: assert property (i_run_set |=> o_run_enable)
		else $error("run enable not set after set pulse");
	AST_RUN_CLR: assert property (i_run_clr && !i_run_set |=> !o_run_enable)
		else $error("run enable not cleared");
	AST_SOFT_HALT: assert property (i_mode == 5'h00 && !o_run_enable && nw |=> $stable(o_count_value))
		else $error("count moved while halted");
	AST_SOFT_ADV: assert property (i_mode == 5'h00 && o_run_enable && nw && !at_per
		|=> o_count_value == $past(o_count_value) + 1'b1)
		else $error("count did not advance");
	AST_SOFT_WRAP: assert property (i_mode == 5'h00 && o_run_enable && nw && at_per
		|=> o_count_value == '0 && o_period_event)
		else $error("no wrap at period");
	AST_ONESHOT_STOP: assert property (i_mode == 5'h08 && o_counting && o_run_enable && at_per && nw && !i_run_set
		|=> !o_run_enable && !o_counting && o_count_value == '0)
		else $error("one-shot did not stop at match");
	AST_MONO_REARM: assert property (i_mode[4:3] == CLASS_MONOSTABLE && i_mode[2:0] inside {3'h1, 3'h2, 3'h3}
		&& o_counting && o_run_enable && at_per && nw && !i_run_clr |=> o_run_enable && o_count_value == '0)
		else $error("monostable match wrong");
	AST_HIGH_LEVEL_RESET: assert property ((i_mode == 5'h07 && o_run_enable && i_external_reset_signal
		&& !i_debug_mode && nw) [*4] |=> o_count_value == '0)
		else $error("count not held at high level");
	AST_DEBUG_HOLD: assert property (i_mode == 5'h04 && o_run_enable && i_debug_mode && dbg4 && nw && !at_per
		|=> o_count_value == $past(o_count_value) + 1'b1)
		else $error("external signal acted in debug");
endmodule : timer_mode_control_checker

// ==== verification/tb.sv ====
// Testbench: scenario tasks for the timer mode control
`timescale 1ns/10ps
`define CHK(nm, exp, got) begin tests_run++; if ((got) !== (exp)) begin mismatches++; \
	$display("Error %s expected %h seen %h", nm, (exp), (got)); end end
module tb;
	import timer_mode_pkg::*;
	logic              i_clk = 1'b0;
	logic              i_rst = 1'b1;
	logic [MODE_W-1:0] i_mode = 5'h00;
	logic              i_run_set = 1'b0;
	logic              i_run_clr = 1'b0;
	logic [7:0]        i_period_value = 8'hc8;
	logic              i_count_write = 1'b0;
	logic [7:0]        i_count_wdata = 8'h00;
	logic              ers_level = 1'b0;
	logic              i_external_reset_signal;
	logic              i_debug_mode = 1'b0;
	logic [7:0]        o_count_value;
	logic              o_run_enable;
	logic              o_period_event;
	logic              o_counting;
	int                mismatches = 0;
	int                tests_run = 0;
	logic [7:0]        held;

	// 25 MHz timer clock
	always #20 i_clk = ~i_clk;

	timer_mode_control #(.COUNT_W(8)) i_timer_mode_control (.i_clk, .i_rst, .i_mode, .i_run_set, .i_run_clr,
		.i_period_value, .i_count_write, .i_count_wdata, .i_external_reset_signal, .i_debug_mode,
		.o_count_value, .o_run_enable, .o_period_event, .o_counting);
	ers_source i_ers_source (.i_clk(i_clk), .i_level(ers_level), .o_ers(i_external_reset_signal));

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	task automatic tick(input int n);
		repeat (n) begin
			@(posedge i_clk);
			#1;
		end
	endtask : tick

	task automatic pulse_run(input logic on);
		if (on) i_run_set = 1'b1;
		else i_run_clr = 1'b1;
		tick(1);
		i_run_set = 1'b0;
		i_run_clr = 1'b0;
	endtask : pulse_run

	// Stop, pick a mode and period, zero the count; callers never pass a reserved code
	task automatic start_mode(input logic [4:0] m, input logic [7:0] per);
		pulse_run(1'b0);
		i_mode = m;
		i_period_value = per;
		i_count_write = 1'b1;
		tick(1);
		i_count_write = 1'b0;
	endtask : start_mode

	// Nine clocks covers the partner gap plus the design's synchroniser
	task automatic pin(input logic lvl);
		ers_level = lvl;
		tick(9);
	endtask : pin

	task automatic wait_idle();
		for (int k = 0; k < 300 && o_counting === 1'b1; k++) tick(1);
	endtask : wait_idle

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task automatic sc_free_run();
		start_mode(5'h00, 8'h02);
		pulse_run(1'b1);
		`CHK("run", 1'b1, o_run_enable)
		tick(3);
		`CHK("wrap", 9'h100, {o_period_event, o_count_value})
		tick(1);
		`CHK("after wrap", 9'h001, {o_period_event, o_count_value})
		pulse_run(1'b0);
		tick(4);
		`CHK("halted", 8'h02, o_count_value)
	endtask : sc_free_run

	// Gate modes and level reset modes: stuck at the gate-off or reset level, free at the other
	task automatic sc_levels();
		for (int i = 0; i < 4; i++) begin
			start_mode((i < 2) ? 5'(1 + i) : 5'(4 + i), 8'hc8);
			pin(i[0]);
			pulse_run(1'b1);
			tick(6);
			`CHK("level stuck", 8'h00, o_count_value)
			pin(~i[0]);
			`CHK("level free", 1'b1, o_count_value != 8'h00)
		end
	endtask : sc_levels

	task automatic sc_edge_reset();
		for (int m = 3; m < 6; m++) begin
			start_mode(5'(m), 8'hc8);
			pin(1'b0);
			pulse_run(1'b1);
			tick(20);
			pin(1'b1);
			`CHK("rise reset", m != 5, o_count_value < 8'h08)
			pin(1'b0);
			`CHK("fall reset", m != 4, o_count_value < 8'h08)
		end
	endtask : sc_edge_reset

	task automatic sc_one_shot();
		start_mode(5'h08, 8'h03);
		pulse_run(1'b1);
		tick(2);
		`CHK("one-shot run", 1'b1, o_counting)
		wait_idle();
		`CHK("one-shot end", 9'h000, {o_run_enable, o_count_value})
	endtask : sc_one_shot

	// Rising, falling and any edge start; each run ends by clearing run enable
	task automatic sc_edge_start();
		for (int i = 0; i < 3; i++) begin
			start_mode(5'(9 + i), 8'h04);
			pin(i == 1);
			pulse_run(1'b1);
			tick(6);
			`CHK("no edge", 9'h100, {o_run_enable, o_count_value})
			pin(i != 1);
			`CHK("edge ran", 9'h000, {o_run_enable, o_count_value})
		end
	endtask : sc_edge_start

	task automatic sc_fresh_edge();
		start_mode(5'h09, 8'hc8);
		pin(1'b0);
		pulse_run(1'b1);
		pin(1'b1);
		pulse_run(1'b0);
		pulse_run(1'b1);
		held = o_count_value;
		pin(1'b0);
		`CHK("no resume", held, o_count_value)
		pin(1'b1);
		`CHK("resumed", 1'b1, o_count_value > held)
	endtask : sc_fresh_edge

	task automatic sc_monostable();
		start_mode(5'h11, 8'h0c);
		pin(1'b0);
		pulse_run(1'b1);
		pin(1'b1);
		wait_idle();
		`CHK("mono end", 9'h100, {o_run_enable, o_count_value})
		pin(1'b0);
		pin(1'b1);
		`CHK("mono restart", 1'b1, o_counting)
		wait_idle();
	endtask : sc_monostable

	task automatic sc_debug();
		start_mode(5'h04, 8'hc8);
		pin(1'b0);
		pulse_run(1'b1);
		tick(10);
		i_debug_mode = 1'b1;
		pin(1'b1);
		pin(1'b0);
		i_debug_mode = 1'b0;
		tick(3);
		`CHK("debug ignores", 1'b1, o_count_value >= 8'h18)
	endtask : sc_debug

	// Rising start with rising reset, then high level start with low level reset
	task automatic sc_hw_reset_shot();
		start_mode(5'h0c, 8'hc8);
		pin(1'b0);
		pulse_run(1'b1);
		tick(3);
		`CHK("shot waits", 8'h00, o_count_value)
		pin(1'b1);
		tick(20);
		pin(1'b0);
		pin(1'b1);
		`CHK("shot edge reset", 1'b1, o_count_value < 8'h08)
		start_mode(5'h16, 8'hc8);
		pin(1'b0);
		pulse_run(1'b1);
		tick(3);
		`CHK("level wait", 9'h000, {o_counting, o_count_value})
		pin(1'b1);
		`CHK("level start", 1'b1, o_counting)
		pin(1'b0);
		`CHK("level reset", 9'h000, {o_counting, o_count_value})
	endtask : sc_hw_reset_shot

	task automatic test_done();
		if (mismatches == 0 && tests_run > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : test_done

	// ------------------------------------------------------------
	// Main sequence and watchdog
	// ------------------------------------------------------------
	initial begin
		tick(6);
		i_rst = 1'b0;
		tick(1);
		sc_free_run();
		sc_levels();
		sc_edge_reset();
		sc_one_shot();
		sc_edge_start();
		sc_fresh_edge();
		sc_monostable();
		sc_debug();
		sc_hw_reset_shot();
		test_done();
	end

	// Whole run needs well under a thousand clocks
	initial begin
		repeat (5000) @(posedge i_clk);
		mismatches++;
		test_done();
	end
endmodule : tb

bind timer_mode_control timer_mode_control_checker #(.COUNT_W(COUNT_W)) i_timer_mode_control_checker (.i_clk,
	.i_rst, .i_mode, .i_run_set, .i_run_clr, .i_period_value, .i_count_write, .i_count_wdata,
	.i_external_reset_signal, .i_debug_mode, .o_count_value, .o_run_enable, .o_period_event, .o_counting);
